// ---- core/drive_cfg_pkg.sv ----
// constants shared by the drive configuration register bank
//--------------------------------------------------------------
// What this block does
// - load stored configuration from flash at start
// - one configuration set, saved as a whole
// - explicit messages use object class 0x64
// - message instance is the register number
// - values are four bytes, MSB first
// - registers 5, 6, 7: velocity, acceleration, torque
// - torque linear, 1023 equals 300 percent peak
// - value 2 to register 211 means save
// - save writes flash, then device resets itself
// - message writes change RAM only until saved
// - no network address settings via messages
// - mode 0 keeps drive passive, else active from one cycle after config_ready rises until one cycle after it falls
//--------------------------------------------------------------
package drive_cfg_pkg;
   // ---------------------------------------------------------
   // message path codes
   // ---------------------------------------------------------
   localparam logic [7:0] REG_CLASS = 8'h64;
   localparam logic [7:0] SVC_GET_SINGLE = 8'h0e;
   localparam logic [7:0] SVC_SET_SINGLE = 8'h10;
   localparam logic [7:0] ATTR_VALUE = 8'h01;
   localparam int MSG_BYTES = 4;
   // ---------------------------------------------------------
   // register numbers (instances)
   // ---------------------------------------------------------
   localparam logic [7:0] INST_MODE = 8'h02;
   localparam logic [7:0] INST_VELOCITY = 8'h05;
   localparam logic [7:0] INST_ACCEL = 8'h06;
   localparam logic [7:0] INST_TORQUE = 8'h07;
   localparam logic [7:0] INST_COMMAND = 8'hd3;
   localparam logic [31:0] CMD_SAVE_FLASH = 32'h0000_0002;
   // ---------------------------------------------------------
   // configuration set layout: slot index and flash word
   // ---------------------------------------------------------
   localparam int CFG_WORDS = 4;
   localparam logic [1:0] SLOT_MODE = 2'h0;
   localparam logic [1:0] SLOT_VELOCITY = 2'h1;
   localparam logic [1:0] SLOT_ACCEL = 2'h2;
   localparam logic [1:0] SLOT_TORQUE = 2'h3;
   localparam logic [31:0] CFG_RESET_VALUE = 32'h0000_0000;
   localparam logic [31:0] MODE_PASSIVE = 32'h0000_0000;
   // ---------------------------------------------------------
   // torque scaling
   // ---------------------------------------------------------
   localparam logic [9:0] TORQUE_FULL_SCALE = 10'h3ff;
   localparam int TORQUE_PEAK_PERCENT = 300;
   // ---------------------------------------------------------
   // answer status codes
   // ---------------------------------------------------------
   localparam logic [7:0] ST_SUCCESS = 8'h00;
   localparam logic [7:0] ST_BAD_PATH = 8'h05;
   localparam logic [7:0] ST_BAD_SERVICE = 8'h08;
   localparam logic [7:0] ST_BAD_VALUE = 8'h09;
   localparam logic [7:0] ST_STATE_CONFLICT = 8'h0c;
   localparam logic [7:0] ST_BAD_ATTRIBUTE = 8'h14;
   // ---------------------------------------------------------
   // control states
   // ---------------------------------------------------------
   typedef enum logic [5:0] {
      ST_LOAD = 6'b000001,
      ST_IDLE = 6'b000010,
      ST_DATA = 6'b000100,
      ST_SAVE = 6'b001000,
      ST_RESET = 6'b010000,
      ST_WAIT = 6'b100000
   } ctrl_state_e;
endpackage

// ---- core/msg_word_pack.sv ----
// collects four message bytes, most significant first, into one word
`timescale 1ns/1ps
module msg_word_pack (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   output logic [31:0] word_q,
   output logic done_q
);
   import drive_cfg_pkg::*;

   logic [1:0] count_q;

   // shift in bytes, first byte ends up on top
   always_ff @(posedge core_clk) begin
      if (rst || clear) begin
         word_q <= 32'h0000_0000;
         count_q <= 2'h0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (byte_valid) begin
            word_q <= {word_q[23:0], byte_in};
            count_q <= count_q + 2'h1;
            done_q <= (count_q == 2'(MSG_BYTES - 1));
         end
      end
   end
endmodule

// ---- core/drive_cfg_regs.sv ----
// drive configuration register bank behind the explicit message path
`timescale 1ns/1ps
module drive_cfg_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic msg_start,
   input wire logic [7:0] msg_service,
   input wire logic [7:0] msg_class,
   input wire logic [7:0] msg_instance,
   input wire logic [7:0] msg_attribute,
   input wire logic msg_byte_valid,
   input wire logic [7:0] msg_byte,
   output logic rsp_valid,
   output logic [7:0] rsp_status,
   output logic [31:0] rsp_data,
   output logic flash_rd,
   output logic flash_wr,
   output logic [1:0] flash_addr,
   output logic [31:0] flash_wdata,
   input wire logic [31:0] flash_rdata,
   input wire logic flash_ack,
   output logic self_reset,
   output logic config_ready,
   output logic drive_enable,
   output logic [31:0] requested_velocity,
   output logic [31:0] requested_acceleration,
   output logic [31:0] torque_limit,
   output logic [9:0] torque_level
);
   import drive_cfg_pkg::*;

   // ---------------------------------------------------------
   // declarations
   // ---------------------------------------------------------
   ctrl_state_e state_q;
   logic [31:0] cfg_q [CFG_WORDS];
   logic [1:0] idx_q;
   logic rd_open_q;
   logic pending_q;
   logic [7:0] svc_q;
   logic [7:0] cls_q;
   logic [7:0] inst_q;
   logic [7:0] attr_q;
   logic [31:0] word;
   logic word_done;
   logic pack_clear;
   logic hdr_ok;
   logic [7:0] hdr_status;
   logic [1:0] slot;
   logic slot_hit;
   logic is_cmd;
   logic rsp_valid_q;
   logic [7:0] rsp_status_q;
   logic [31:0] rsp_data_q;
   logic flash_rd_q;
   logic flash_wr_q;
   logic [31:0] flash_wdata_q;
   logic self_reset_q;
   logic ready_q;
   logic enable_q;
   logic [9:0] torque_q;

   // ---------------------------------------------------------
   // byte assembly of the request value
   // ---------------------------------------------------------
   assign pack_clear = msg_start;

   msg_word_pack u_pack (
      .core_clk(core_clk),
      .rst(rst),
      .clear(pack_clear),
      .byte_valid(msg_byte_valid && (state_q == ST_DATA)),
      .byte_in(msg_byte),
      .word_q(word),
      .done_q(word_done)
   );

   // ---------------------------------------------------------
   // request decode
   // ---------------------------------------------------------
   // register number picks a configuration slot directly
   always_comb begin
      slot = SLOT_MODE;
      slot_hit = 1'b1;
      is_cmd = (inst_q == INST_COMMAND);
      unique case (inst_q)
         INST_MODE: slot = SLOT_MODE;
         INST_VELOCITY: slot = SLOT_VELOCITY;
         INST_ACCEL: slot = SLOT_ACCEL;
         INST_TORQUE: slot = SLOT_TORQUE;
         default: slot_hit = 1'b0; // network settings not reachable here
      endcase
   end

   // header check: class, service, attribute, register number
   always_comb begin
      hdr_ok = 1'b0;
      hdr_status = ST_SUCCESS;
      if (cls_q != REG_CLASS) begin
         hdr_status = ST_BAD_PATH;
      end else if (svc_q != SVC_SET_SINGLE && svc_q != SVC_GET_SINGLE) begin
         hdr_status = ST_BAD_SERVICE;
      end else if (attr_q != ATTR_VALUE) begin
         hdr_status = ST_BAD_ATTRIBUTE;
      end else if (!slot_hit && !is_cmd) begin
         hdr_status = ST_BAD_PATH; // unknown register rejected
      end else if (is_cmd && svc_q == SVC_GET_SINGLE) begin
         hdr_status = ST_BAD_SERVICE; // command register is write only
      end else begin
         hdr_ok = 1'b1;
      end
   end

   // ---------------------------------------------------------
   // header latch
   // ---------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         svc_q <= 8'h00;
         cls_q <= 8'h00;
         inst_q <= 8'h00;
         attr_q <= 8'h00;
         pending_q <= 1'b0;
      end else begin
         pending_q <= 1'b0;
         if (msg_start) begin
            svc_q <= msg_service;
            cls_q <= msg_class;
            inst_q <= msg_instance;
            attr_q <= msg_attribute;
            pending_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------
   // control sequence: load, serve, save, self reset
   // ---------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ST_LOAD;
         idx_q <= 2'h0;
         rd_open_q <= 1'b0;
         flash_rd_q <= 1'b0;
         flash_wr_q <= 1'b0;
         flash_wdata_q <= 32'h0000_0000;
         self_reset_q <= 1'b0;
         ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_status_q <= ST_SUCCESS;
         rsp_data_q <= 32'h0000_0000;
         for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_q[i] <= CFG_RESET_VALUE;
         end
      end else begin
         flash_rd_q <= 1'b0;
         flash_wr_q <= 1'b0;
         self_reset_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         unique case (state_q)
            // copy the stored set into working RAM, one word per ack
            ST_LOAD: begin
               ready_q <= 1'b0;
               if (flash_ack) begin
                  cfg_q[idx_q] <= flash_rdata;
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'(CFG_WORDS - 1)) begin
                     state_q <= ST_IDLE;
                     ready_q <= 1'b1;
                     rd_open_q <= 1'b0;
                  end else begin
                     flash_rd_q <= 1'b1;
                  end
               end else if (!rd_open_q) begin
                  // one read in flight only, a repeat would restart the flash
                  flash_rd_q <= 1'b1;
                  rd_open_q <= 1'b1;
               end
               if (pending_q) begin
                  rsp_valid_q <= 1'b1;
                  rsp_status_q <= ST_STATE_CONFLICT;
                  rsp_data_q <= 32'h0000_0000;
               end
            end
            // take a new request
            ST_IDLE: begin
               if (pending_q) begin
                  if (hdr_ok && svc_q == SVC_SET_SINGLE) begin
                     state_q <= ST_DATA;
                  end else begin
                     rsp_valid_q <= 1'b1;
                     rsp_status_q <= hdr_status;
                     rsp_data_q <= hdr_ok ? cfg_q[slot] : 32'h0000_0000;
                  end
               end
            end
            // wait for the four value bytes, then apply
            ST_DATA: begin
               if (pending_q) begin
                  state_q <= ST_IDLE; // new header aborts the write and gets a busy answer here
                  rsp_valid_q <= 1'b1;
                  rsp_status_q <= ST_STATE_CONFLICT;
                  rsp_data_q <= 32'h0000_0000;
               end else if (word_done) begin
                  rsp_valid_q <= 1'b1;
                  rsp_data_q <= 32'h0000_0000;
                  state_q <= ST_IDLE;
                  if (is_cmd) begin
                     if (word == CMD_SAVE_FLASH) begin
                        rsp_status_q <= ST_SUCCESS;
                        state_q <= ST_SAVE;
                        idx_q <= 2'h0;
                        flash_wr_q <= 1'b1;
                        flash_wdata_q <= cfg_q[0];
                        ready_q <= 1'b0;
                     end else begin
                        rsp_status_q <= ST_BAD_VALUE;
                     end
                  end else begin
                     cfg_q[slot] <= word; // RAM only
                     rsp_status_q <= ST_SUCCESS;
                  end
               end
            end
            // write the single set into flash, word by word
            ST_SAVE: begin
               if (pending_q) begin
                  rsp_valid_q <= 1'b1;
                  rsp_status_q <= ST_STATE_CONFLICT;
                  rsp_data_q <= 32'h0000_0000;
               end
               if (flash_ack) begin
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == 2'(CFG_WORDS - 1)) begin
                     state_q <= ST_RESET;
                  end else begin
                     flash_wr_q <= 1'b1;
                     flash_wdata_q <= cfg_q[idx_q + 2'h1];
                  end
               end
            end
            // announce self reset, drop RAM, reload from flash
            ST_RESET: begin
               self_reset_q <= 1'b1;
               idx_q <= 2'h0;
               rd_open_q <= 1'b0;
               state_q <= ST_WAIT;
               for (int i = 0; i < CFG_WORDS; i++) begin
                  cfg_q[i] <= CFG_RESET_VALUE;
               end
               // a header arriving now still gets a busy answer
               if (pending_q) begin
                  rsp_valid_q <= 1'b1;
                  rsp_status_q <= ST_STATE_CONFLICT;
                  rsp_data_q <= 32'h0000_0000;
               end
            end
            ST_WAIT: begin
               state_q <= ST_LOAD;
               if (pending_q) begin
                  rsp_valid_q <= 1'b1;
                  rsp_status_q <= ST_STATE_CONFLICT;
                  rsp_data_q <= 32'h0000_0000;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------
   // drive outputs: enable and torque level
   // ---------------------------------------------------------
   // passive from one cycle after mode holds zero or the set is not loaded
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= ready_q && (cfg_q[SLOT_MODE] != MODE_PASSIVE);
      end
   end

   // linear torque, clamped at full scale (peak torque)
   always_ff @(posedge core_clk) begin
      if (rst) begin
         torque_q <= 10'h000;
      end else if (cfg_q[SLOT_TORQUE] > {22'h000000, TORQUE_FULL_SCALE}) begin
         torque_q <= TORQUE_FULL_SCALE;
      end else begin
         torque_q <= cfg_q[SLOT_TORQUE][9:0];
      end
   end

   // ---------------------------------------------------------
   // port assignments, all from flip-flops
   // ---------------------------------------------------------
   assign rsp_valid = rsp_valid_q;
   assign rsp_status = rsp_status_q;
   assign rsp_data = rsp_data_q;
   assign flash_rd = flash_rd_q;
   assign flash_wr = flash_wr_q;
   assign flash_addr = idx_q;
   assign flash_wdata = flash_wdata_q;
   assign self_reset = self_reset_q;
   assign config_ready = ready_q;
   assign drive_enable = enable_q;
   assign requested_velocity = cfg_q[SLOT_VELOCITY];
   assign requested_acceleration = cfg_q[SLOT_ACCEL];
   assign torque_limit = cfg_q[SLOT_TORQUE];
   assign torque_level = torque_q;
endmodule

// ---- bench/flash_model.sv ----
// behavioural flash word store facing the register bank
`timescale 1ns/1ps
module flash_model #(
   parameter int ACK_DELAY = 3
) (
   input wire logic core_clk,
   input wire logic flash_rd,
   input wire logic flash_wr,
   input wire logic [1:0] flash_addr,
   input wire logic [31:0] flash_wdata,
   output logic [31:0] flash_rdata,
   output logic flash_ack
);
   logic [31:0] mem [4];
   int cnt = 0;
   logic rd_q = 1'b0;
   logic [1:0] addr_q = 2'h0;
   // preset stored set: mode, velocity, acceleration, torque
   initial begin
      mem = '{32'h0000_0001, 32'h0000_0115, 32'h0000_0024, 32'h0000_0200};
      flash_rdata = 32'h0;
      flash_ack = 1'b0;
   end
   // one access at a time; read data is only valid beside the ack
   always @(posedge core_clk) begin
      flash_ack <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_rd || flash_wr) begin
         cnt <= ACK_DELAY;
         rd_q <= flash_rd;
         addr_q <= flash_addr;
         if (flash_wr) mem[flash_addr] <= flash_wdata;
      end else if (cnt == 1) begin
         cnt <= 0;
         flash_ack <= 1'b1;
         if (rd_q) flash_rdata <= mem[addr_q];
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ---- bench/drive_cfg_regs_sva.sv ----
// assertions on the drive configuration bank ports
`timescale 1ns/1ps
module drive_cfg_regs_sva
   import drive_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic msg_start,
   input wire logic [7:0] msg_service,
   input wire logic [7:0] msg_class,
   input wire logic [7:0] msg_instance,
   input wire logic [7:0] msg_attribute,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_status,
   input wire logic flash_rd,
   input wire logic flash_wr,
   input wire logic [1:0] flash_addr,
   input wire logic flash_ack,
   input wire logic self_reset,
   input wire logic config_ready,
   input wire logic drive_enable,
   input wire logic [31:0] torque_limit,
   input wire logic [9:0] torque_level
);
   logic [9:0] clamp_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // expected torque level, one cycle behind the limit word
   always_ff @(posedge core_clk) begin
      if (rst) clamp_q <= 10'h0;
      else clamp_q <= (torque_limit > 32'h3ff) ? TORQUE_FULL_SCALE : torque_limit[9:0];
   end
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer strobe longer than one cycle");
   a_get_answer: assert property (msg_start && msg_service == SVC_GET_SINGLE |-> ##2 rsp_valid)
      else $error("read answer late");
   a_bad_class: assert property (msg_start && msg_class != REG_CLASS |-> ##2 (rsp_valid && rsp_status != ST_SUCCESS))
      else $error("foreign class accepted");
   a_bad_attr: assert property (msg_start && config_ready && msg_class == REG_CLASS && msg_service == SVC_SET_SINGLE
      && msg_instance == INST_VELOCITY && msg_attribute != ATTR_VALUE |-> ##2 (rsp_valid && rsp_status == ST_BAD_ATTRIBUTE))
      else $error("bad attribute not refused");
   a_enable_ready: assert property (drive_enable |-> $past(config_ready))
      else $error("drive enabled without loaded set");
   a_enable_drop: assert property (!config_ready |=> !drive_enable)
      else $error("drive stayed enabled after set unloaded");
   a_torque_clamp: assert property (torque_level == clamp_q)
      else $error("torque level wrong");
   a_flash_single: assert property (!(flash_rd && flash_wr))
      else $error("flash read and write together");
   a_flash_step: assert property (flash_ack && !config_ready && flash_addr != 2'h3
      |=> (flash_rd || flash_wr) && flash_addr == $past(flash_addr) + 2'h1)
      else $error("flash word order broken");
   a_save_first: assert property (flash_wr && rsp_valid |-> flash_addr == SLOT_MODE && rsp_status == ST_SUCCESS)
      else $error("save did not start at first word");
   a_reset_reload: assert property (self_reset |-> ##[1:3] (flash_rd && flash_addr == SLOT_MODE && !config_ready))
      else $error("no reload after self reset");
   c_save: cover property (self_reset);
   c_bad_path: cover property (rsp_valid && rsp_status == ST_BAD_PATH);
   c_enabled: cover property (drive_enable);
endmodule
bind drive_cfg_regs drive_cfg_regs_sva i_sva (.core_clk, .rst, .msg_start, .msg_service, .msg_class, .msg_instance,
   .msg_attribute, .rsp_valid, .rsp_status, .flash_rd, .flash_wr, .flash_addr, .flash_ack, .self_reset,
   .config_ready, .drive_enable, .torque_limit, .torque_level);

// ---- bench/testbench.sv ----
// self-checking bench for the drive configuration register bank
`timescale 1ns/1ps
module testbench;
   import drive_cfg_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, msg_start = 1'b0, msg_byte_valid = 1'b0;
   logic [7:0] msg_service = 8'h0, msg_class = 8'h0, msg_instance = 8'h0, msg_attribute = 8'h0, msg_byte = 8'h0;
   logic rsp_valid, flash_rd, flash_wr, flash_ack, self_reset, config_ready, drive_enable;
   logic [7:0] rsp_status, st;
   logic [31:0] rsp_data, flash_wdata, flash_rdata, requested_velocity, requested_acceleration, torque_limit, rd;
   logic [1:0] flash_addr;
   logic [9:0] torque_level;
   int mismatches = 0, total_checks = 0, cycles = 0;
   drive_cfg_regs i_drive_cfg_regs (.core_clk, .rst, .msg_start, .msg_service, .msg_class, .msg_instance,
      .msg_attribute, .msg_byte_valid, .msg_byte, .rsp_valid, .rsp_status, .rsp_data, .flash_rd, .flash_wr,
      .flash_addr, .flash_wdata, .flash_rdata, .flash_ack, .self_reset, .config_ready, .drive_enable,
      .requested_velocity, .requested_acceleration, .torque_limit, .torque_level);
   flash_model i_flash_model (.core_clk, .flash_rd, .flash_wr, .flash_addr, .flash_wdata, .flash_rdata, .flash_ack);
   initial forever #25 core_clk = ~core_clk;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one explicit message; value bytes go out most significant first
   task automatic msg(input logic [7:0] svc, cls, inst, attr, input logic [31:0] val, input bit with_data);
      int n;
      @(negedge core_clk);
      msg_service = svc;
      msg_class = cls;
      msg_instance = inst;
      msg_attribute = attr;
      msg_start = 1'b1;
      @(negedge core_clk);
      msg_start = 1'b0;
      if (with_data) begin
         @(negedge core_clk);
         for (int i = 3; i >= 0; i--) begin
            msg_byte_valid = 1'b1;
            msg_byte = val[8*i +: 8];
            @(negedge core_clk);
         end
         msg_byte_valid = 1'b0;
      end
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
      st = rsp_status;
      rd = rsp_data;
   endtask
   task automatic set_reg(input logic [7:0] inst, input logic [31:0] val, input logic [7:0] exp);
      msg(SVC_SET_SINGLE, REG_CLASS, inst, ATTR_VALUE, val, 1'b1);
      chk("set status", {24'h0, exp}, {24'h0, st});
   endtask
   task automatic wait_ready();
      int n = 0;
      while (config_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk("config_ready", 32'h1, {31'h0, config_ready});
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_load();
      msg(SVC_GET_SINGLE, REG_CLASS, INST_VELOCITY, ATTR_VALUE, 32'h0, 1'b0);
      chk("busy status", {24'h0, ST_STATE_CONFLICT}, {24'h0, st});
      wait_ready();
      chk("velocity", 32'h0000_0115, requested_velocity);
      chk("accel", 32'h0000_0024, requested_acceleration);
      chk("torque", 32'h0000_0200, torque_limit);
      @(negedge core_clk); // enable follows ready one cycle later
      chk("enable", 32'h1, {31'h0, drive_enable});
   endtask
   task automatic t_writes();
      set_reg(INST_VELOCITY, 32'h0000_0ad2, ST_SUCCESS);
      set_reg(INST_ACCEL, 32'h0000_0048, ST_SUCCESS);
      set_reg(INST_TORQUE, 32'h0000_00ff, ST_SUCCESS);
      @(negedge core_clk); // torque level lags the word by one cycle
      chk("velocity", 32'h0000_0ad2, requested_velocity);
      chk("accel", 32'h0000_0048, requested_acceleration);
      chk("torque level", 32'h0000_00ff, {22'h0, torque_level});
      msg(SVC_GET_SINGLE, REG_CLASS, INST_VELOCITY, ATTR_VALUE, 32'h0, 1'b0);
      chk("get data", 32'h0000_0ad2, rd);
      chk("flash velocity", 32'h0000_0115, i_flash_model.mem[1]);
      set_reg(INST_TORQUE, 32'h0000_0500, ST_SUCCESS);
      @(negedge core_clk);
      chk("torque clamp", 32'h0000_03ff, {22'h0, torque_level});
   endtask
   task automatic t_errors();
      logic [39:0] tab [5] = '{{SVC_SET_SINGLE, 8'h65, INST_VELOCITY, ATTR_VALUE, ST_BAD_PATH},
         {SVC_SET_SINGLE, REG_CLASS, 8'h0a, ATTR_VALUE, ST_BAD_PATH},
         {SVC_SET_SINGLE, REG_CLASS, INST_VELOCITY, 8'h02, ST_BAD_ATTRIBUTE},
         {SVC_GET_SINGLE, REG_CLASS, INST_COMMAND, ATTR_VALUE, ST_BAD_SERVICE},
         {8'h4b, REG_CLASS, INST_VELOCITY, ATTR_VALUE, ST_BAD_SERVICE}};
      foreach (tab[i]) begin
         msg(tab[i][39:32], tab[i][31:24], tab[i][23:16], tab[i][15:8], 32'h0, 1'b0);
         chk("error status", {24'h0, tab[i][7:0]}, {24'h0, st});
      end
      chk("velocity kept", 32'h0000_0ad2, requested_velocity);
      set_reg(INST_COMMAND, 32'h0000_0003, ST_BAD_VALUE);
      chk("no save", 32'h0, {31'h0, self_reset});
   endtask
   task automatic t_mode();
      set_reg(INST_MODE, 32'h0, ST_SUCCESS);
      @(negedge core_clk);
      chk("passive", 32'h0, {31'h0, drive_enable});
      set_reg(INST_MODE, 32'h1, ST_SUCCESS);
      @(negedge core_clk);
      chk("active", 32'h1, {31'h0, drive_enable});
   endtask
   task automatic t_save();
      int n = 0;
      set_reg(INST_COMMAND, CMD_SAVE_FLASH, ST_SUCCESS);
      while (self_reset !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk("self reset", 32'h1, {31'h0, self_reset});
      chk("flash mode", 32'h1, i_flash_model.mem[0]);
      chk("flash velocity", 32'h0000_0ad2, i_flash_model.mem[1]);
      chk("flash accel", 32'h0000_0048, i_flash_model.mem[2]);
      chk("flash torque", 32'h0000_0500, i_flash_model.mem[3]);
      wait_ready();
      chk("reloaded velocity", 32'h0000_0ad2, requested_velocity);
   endtask
   // stimulus runs on falling edges
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      t_load();
      t_writes();
      t_errors();
      t_mode();
      t_save();
      summarize();
   end
   // guard against a hung handshake
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end
endmodule
